// ---- hdl/adcreg_bank.sv ----
// Identity, power and serial interface configuration registers
// Assumes the serial command decoder delivers one-cycle read and write strobes
// on clk, already decoded from the register read and write commands
`include "adcreg_params.svh"
`default_nettype none

module adcreg_bank
  import adcreg_pkg::*;
#(
  parameter logic [2:0] VARIANT_CODE  = `ADCREG_VARIANT_DEFAULT,
  parameter logic [4:0] REVISION_CODE = `ADCREG_REVISION_DEFAULT
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             reg_write_cmd,
  input  wire logic             reg_read_cmd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output var  logic [7:0]       reg_rdata,
  output var  logic             reg_rvalid,
  output var  logic             reg_addr_error,
  output var  logic             level_shift_enable,
  output var  logic             internal_ref_enable,
  output var  logic             timeout_enable,
  output var  logic             status_byte_enable,
  output var  adcreg_check_type check_mode
);
  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]       power_reg;
  logic [7:0]       interface_reg;
  logic [7:0]       next_power_reg;
  logic [7:0]       next_interface_reg;
  logic [7:0]       next_reg_rdata;
  logic             next_reg_rvalid;
  logic             next_reg_addr_error;
  logic             next_level_shift_enable;
  logic             next_internal_ref_enable;
  logic             next_timeout_enable;
  logic             next_status_byte_enable;
  adcreg_check_type next_check_mode;
  logic             write_taken;
  logic             read_taken;
  adcreg_cfg_if     cfg ();

  // ****************************************
  // Helpers
  // ****************************************
  // Only three offsets exist; anything else answers with an error pulse
  function automatic logic offset_mapped(input logic [7:0] offset);
    return (offset == `ADCREG_OFS_IDENTITY) ||
           (offset == `ADCREG_OFS_POWER) ||
           (offset == `ADCREG_OFS_INTERFACE);
  endfunction

  // Reset flag only clears by write; a written 1 cannot fake a reset
  function automatic logic [7:0] merge_power(input logic [7:0] stored,
                                             input logic [7:0] data);
    logic [7:0] merged;
    merged = data & `ADCREG_POWER_MASK;
    merged[`ADCREG_PWR_RESET_FLAG] =
      stored[`ADCREG_PWR_RESET_FLAG] & data[`ADCREG_PWR_RESET_FLAG];
    return merged;
  endfunction

  // Reserved check code keeps the old code so the framer never sees it
  // Other fields of the same write still land
  function automatic logic [7:0] merge_interface(input logic [7:0] stored,
                                                 input logic [7:0] data);
    logic [7:0] merged;
    merged = data & `ADCREG_INTERFACE_MASK;
    if (data[`ADCREG_IF_CHECK_MSB:`ADCREG_IF_CHECK_LSB] == `ADCREG_CHECK_RESERVED) begin
      merged[`ADCREG_IF_CHECK_MSB:`ADCREG_IF_CHECK_LSB] =
        stored[`ADCREG_IF_CHECK_MSB:`ADCREG_IF_CHECK_LSB];
    end
    return merged;
  endfunction

  // Identity is built from parameters and has no write path at all
  function automatic logic [7:0] read_mux(input logic [7:0] offset,
                                          input logic [7:0] power_byte,
                                          input logic [7:0] interface_byte);
    logic [7:0] value;
    value = 8'h00;
    unique case (offset)
      `ADCREG_OFS_IDENTITY:  value = {VARIANT_CODE, REVISION_CODE};
      `ADCREG_OFS_POWER:     value = power_byte;
      `ADCREG_OFS_INTERFACE: value = interface_byte;
      default:               value = 8'h00;
    endcase
    return value;
  endfunction

  // ****************************************
  // Command qualification
  // ****************************************
  // Write wins when both strobes meet, so one edge never does two things
  assign write_taken = reg_write_cmd;
  assign read_taken  = reg_read_cmd & ~reg_write_cmd;

  // ****************************************
  // Field decoder
  // ****************************************
  assign cfg.power_raw     = power_reg;
  assign cfg.interface_raw = interface_reg;

  adcreg_field_decode u_decode (
    .cfg (cfg)
  );

  // ****************************************
  // Power register
  // ****************************************
  always_comb begin
    next_power_reg = power_reg;
    if (write_taken && (reg_addr == `ADCREG_OFS_POWER)) begin
      next_power_reg = merge_power(power_reg, reg_wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // Reset beats a clearing write in the same cycle, so no reset goes unseen
      power_reg <= `ADCREG_POWER_RESET;
    end else begin
      power_reg <= next_power_reg;
    end
  end

  // ****************************************
  // Interface register
  // ****************************************
  // Reserved bits are masked at the write, so reads need no extra gating
  always_comb begin
    next_interface_reg = interface_reg;
    if (write_taken && (reg_addr == `ADCREG_OFS_INTERFACE)) begin
      next_interface_reg = merge_interface(interface_reg, reg_wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      interface_reg <= `ADCREG_INTERFACE_RESET;
    end else begin
      interface_reg <= next_interface_reg;
    end
  end

  // ****************************************
  // Read response
  // ****************************************
  // Read data holds until the next read so a slow host can still take it
  always_comb begin
    next_reg_rdata      = reg_rdata;
    next_reg_rvalid     = 1'b0;
    next_reg_addr_error = 1'b0;
    if (write_taken) begin
      next_reg_addr_error = ~offset_mapped(reg_addr);
    end else if (read_taken) begin
      next_reg_rvalid     = 1'b1;
      next_reg_rdata      = read_mux(reg_addr, power_reg, interface_reg);
      next_reg_addr_error = ~offset_mapped(reg_addr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata      <= 8'h00;
      reg_rvalid     <= 1'b0;
      reg_addr_error <= 1'b0;
    end else begin
      reg_rdata      <= next_reg_rdata;
      reg_rvalid     <= next_reg_rvalid;
      reg_addr_error <= next_reg_addr_error;
    end
  end

  // ****************************************
  // Control outputs
  // ****************************************
  // Control outputs lag the stored byte by one cycle to come from flops
  always_comb begin
    next_level_shift_enable  = cfg.level_shift_enable;
    next_internal_ref_enable = cfg.internal_ref_enable;
    next_timeout_enable      = cfg.timeout_enable;
    next_status_byte_enable  = cfg.status_byte_enable;
    next_check_mode          = cfg.check_mode;
  end

  // Reset values match the reset bytes so no glitch shows after release
  always_ff @(posedge clk) begin
    if (rst) begin
      level_shift_enable  <= 1'b0;
      internal_ref_enable <= 1'b1;
      timeout_enable      <= 1'b0;
      status_byte_enable  <= 1'b1;
      check_mode          <= ADCREG_CHK_SUM;
    end else begin
      level_shift_enable  <= next_level_shift_enable;
      internal_ref_enable <= next_internal_ref_enable;
      timeout_enable      <= next_timeout_enable;
      status_byte_enable  <= next_status_byte_enable;
      check_mode          <= next_check_mode;
    end
  end
endmodule
`default_nettype wire

// ---- include/adcreg_params.svh ----
// Offsets, field positions, reset values and codes of the identity, power and interface registers
// Assumes inclusion by bare name from package and design files
`ifndef ADCREG_PARAMS_SVH
`define ADCREG_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADCREG_OFS_IDENTITY   8'h00
`define ADCREG_OFS_POWER      8'h01
`define ADCREG_OFS_INTERFACE  8'h02

// ****************************************
// Field positions
// ****************************************
`define ADCREG_ID_VARIANT_MSB    7
`define ADCREG_ID_VARIANT_LSB    5
`define ADCREG_ID_REVISION_MSB   4
`define ADCREG_ID_REVISION_LSB   0
`define ADCREG_PWR_RESET_FLAG    4
`define ADCREG_PWR_LEVEL_SHIFT   1
`define ADCREG_PWR_INT_REF       0
`define ADCREG_IF_TIMEOUT        3
`define ADCREG_IF_STATUS         2
`define ADCREG_IF_CHECK_MSB      1
`define ADCREG_IF_CHECK_LSB      0

// ****************************************
// Reset values and masks
// ****************************************
`define ADCREG_POWER_RESET      8'h11
`define ADCREG_INTERFACE_RESET  8'h05
`define ADCREG_POWER_MASK       8'h13
`define ADCREG_INTERFACE_MASK   8'h0F

// ****************************************
// Check byte codes
// ****************************************
`define ADCREG_CHECK_NONE      2'h0
`define ADCREG_CHECK_SUM       2'h1
`define ADCREG_CHECK_CRC       2'h2
`define ADCREG_CHECK_RESERVED  2'h3

// Arbitrary identity values, not tied to any real part
`define ADCREG_VARIANT_DEFAULT   3'h5
`define ADCREG_REVISION_DEFAULT  5'h0A

`endif

// ---- include/adcreg_pkg.sv ----
// Types shared by the register bank and its field decoder
// Assumes adcreg_params.svh on the include path
`default_nettype none
package adcreg_pkg;
  typedef enum logic [1:0] {
    ADCREG_CHK_NONE,
    ADCREG_CHK_SUM,
    ADCREG_CHK_CRC,
    ADCREG_CHK_RSVD
  } adcreg_check_type;

  typedef enum logic {
    ADCREG_IDLE,
    ADCREG_DONE
  } adcreg_state_type;
endpackage
`default_nettype wire

// ---- include/adcreg_cfg_if.sv ----
// Carrier between the register bank and its field decoder
// Assumes one clock domain; purely combinational signals
`default_nettype none
interface adcreg_cfg_if;
  import adcreg_pkg::*;
  logic [7:0]       power_raw;
  logic [7:0]       interface_raw;
  logic             level_shift_enable;
  logic             internal_ref_enable;
  logic             timeout_enable;
  logic             status_byte_enable;
  adcreg_check_type check_mode;

  modport bank (
    output power_raw,
    output interface_raw,
    input  level_shift_enable,
    input  internal_ref_enable,
    input  timeout_enable,
    input  status_byte_enable,
    input  check_mode
  );
  modport decode (
    input  power_raw,
    input  interface_raw,
    output level_shift_enable,
    output internal_ref_enable,
    output timeout_enable,
    output status_byte_enable,
    output check_mode
  );
endinterface
`default_nettype wire

// ---- hdl/adcreg_field_decode.sv ----
// Splits stored power and interface bytes into named control fields
// Assumes raw bytes already hold zeros in reserved positions
`include "adcreg_params.svh"
`default_nettype none
module adcreg_field_decode
  import adcreg_pkg::*;
(
  adcreg_cfg_if.decode cfg
);
  // ****************************************
  // Field decode
  // ****************************************
  always_comb begin
    cfg.level_shift_enable  = cfg.power_raw[`ADCREG_PWR_LEVEL_SHIFT];
    cfg.internal_ref_enable = cfg.power_raw[`ADCREG_PWR_INT_REF];
    cfg.timeout_enable      = cfg.interface_raw[`ADCREG_IF_TIMEOUT];
    cfg.status_byte_enable  = cfg.interface_raw[`ADCREG_IF_STATUS];
    cfg.check_mode          = adcreg_check_type'(
      cfg.interface_raw[`ADCREG_IF_CHECK_MSB:`ADCREG_IF_CHECK_LSB]);
  end
endmodule
`default_nettype wire

// ---- verif/adcreg_bank_sva.sv ----
// Port checker for the identity, power and interface register bank
// Assumes binding onto adcreg_bank, single clock domain
`default_nettype none
module adcreg_bank_sva
  import adcreg_pkg::*;
#(
  // Arbitrary defaults; the bind passes the design's own values
  parameter logic [2:0] VARIANT_CODE  = 3'h5,
  parameter logic [4:0] REVISION_CODE = 5'h0A
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             reg_write_cmd,
  input wire logic             reg_read_cmd,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic [7:0]       reg_rdata,
  input wire logic             reg_rvalid,
  input wire logic             reg_addr_error,
  input wire logic             level_shift_enable,
  input wire logic             internal_ref_enable,
  input wire logic             timeout_enable,
  input wire logic             status_byte_enable,
  input wire adcreg_check_type check_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_read_answer: assert property (reg_read_cmd && !reg_write_cmd && reg_addr < 8'h03
    |=> reg_rvalid && !reg_addr_error) else $error("read not answered");
  chk_idle_quiet: assert property (!(reg_read_cmd && !reg_write_cmd) |=> !reg_rvalid)
    else $error("stray read valid");
  chk_unmapped_flag: assert property ((reg_read_cmd || reg_write_cmd) && reg_addr > 8'h02
    |=> reg_addr_error) else $error("unmapped access not flagged");
  chk_identity_value: assert property (reg_read_cmd && !reg_write_cmd && reg_addr == 8'h00
    |=> reg_rdata == {VARIANT_CODE, REVISION_CODE}) else $error("identity wrong");
  chk_power_reserved: assert property (reg_read_cmd && !reg_write_cmd && reg_addr == 8'h01
    |=> (reg_rdata & 8'hEC) == 8'h00) else $error("power reserved bits set");
  chk_iface_reserved: assert property (reg_read_cmd && !reg_write_cmd && reg_addr == 8'h02
    |=> reg_rdata[7:4] == 4'h0) else $error("interface reserved bits set");
  chk_power_ctrl: assert property (reg_write_cmd && reg_addr == 8'h01 |-> ##2
    {level_shift_enable, internal_ref_enable} == $past(reg_wdata[1:0], 2))
    else $error("power controls wrong");
  chk_iface_ctrl: assert property (reg_write_cmd && reg_addr == 8'h02
    && reg_wdata[1:0] != 2'h3
    |-> ##2 {timeout_enable, status_byte_enable, check_mode} == $past(reg_wdata[3:0], 2))
    else $error("interface controls wrong");
  chk_reset_defaults: assert property (disable iff (1'b0) rst [*3] |-> !reg_rvalid
    && !level_shift_enable && internal_ref_enable && !timeout_enable && status_byte_enable
    && check_mode == ADCREG_CHK_SUM) else $error("reset defaults wrong");
endmodule
bind adcreg_bank adcreg_bank_sva #(.VARIANT_CODE(VARIANT_CODE), .REVISION_CODE(REVISION_CODE))
  u_sva (.clk(clk), .rst(rst), .reg_write_cmd(reg_write_cmd), .reg_read_cmd(reg_read_cmd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .reg_addr_error(reg_addr_error), .level_shift_enable(level_shift_enable),
  .internal_ref_enable(internal_ref_enable), .timeout_enable(timeout_enable),
  .status_byte_enable(status_byte_enable), .check_mode(check_mode));
`default_nettype wire

// ---- verif/adcreg_host.sv ----
// Host controller model issuing register read and write commands
// Assumes the bank takes a command at the edge where it is held
`default_nettype none
module adcreg_host (
  input  wire logic       clk,
  output var  logic       wr    = 1'b0,
  output var  logic       rd    = 1'b0,
  output var  logic [7:0] addr  = 8'h00,
  output var  logic [7:0] wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // Revision code is never relied upon here
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    // Released lines show the inverse so stale values cannot pass
    addr <= ~a;
    wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- verif/adc_id_power_interface_regs_tb.sv ----
// Self-checking bench of the register bank against an integer model
// Assumes the host model in adcreg_host and the bound checker
`default_nettype none
module adc_id_power_interface_regs_tb;
  import adcreg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             wr, rd, rvalid, aerr, ls, ir, to, sb;
  logic [7:0]       addr, wdata, rdata;
  adcreg_check_type cm;
  int               errors = 0;
  int               compares = 0;
  int               cycles = 0;
  int               pwr, ifc;
  logic             sensors = 1'b0;
  adcreg_host host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
  adcreg_bank #(.VARIANT_CODE(3'h2), .REVISION_CODE(5'h13)) dut (.clk(clk), .rst(rst),
    .reg_write_cmd(wr), .reg_read_cmd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_addr_error(aerr), .level_shift_enable(ls),
    .internal_ref_enable(ir), .timeout_enable(to), .status_byte_enable(sb), .check_mode(cm));
  initial forever #20 clk = ~clk;
  task automatic results();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far above the 141 to 181 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      errors++;
      results();
    end
  end
  task automatic chk(string n, int e, logic [7:0] g);
    compares++;
    if (g !== 8'(e)) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, 8'(e), g);
    end
  endtask
  task automatic ctl();
    chk("power_ctl", pwr & 3, {6'h00, ls, ir});
    chk("iface_ctl", ifc & 'hF, {4'h0, to, sb, cm});
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    int e;
    if (w && a == 8'h01 && sensors) d[0] = 1'b1;
    host.xfer(w, a, d);
    #1;
    e = a == 0 ? 'h53 : a == 1 ? pwr : a == 2 ? ifc : 0;
    if (w && a == 1) pwr = (d & 'h03) | (pwr & d & 'h10);
    if (w && a == 2) ifc = (d & 'h0C) | (d[1:0] == 2'h3 ? ifc & 3 : d & 3);
    chk("addr_error", a > 2, aerr);
    if (!w) chk("rdata", e, rdata);
    chk("rvalid", !w, rvalid);
    if (w) begin
      @(posedge clk);
      #1;
      ctl();
    end
  endtask
  task automatic rst_dut();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    pwr = 'h11;
    ifc = 'h05;
  endtask
  initial begin
    void'($urandom(34));
    rst_dut();
    for (int a = 0; a < 4; a++) acc(1'b0, 8'(a), 8'h00);
    ctl();
    acc(1'b1, 8'h00, 8'hFF);
    acc(1'b0, 8'h00, 8'h00);
    acc(1'b1, 8'h01, 8'hFF);
    acc(1'b1, 8'h01, 8'hEC);
    acc(1'b1, 8'h01, 8'h10);
    acc(1'b0, 8'h01, 8'h00);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 8'h02, 8'hF8 | 8'(c));
      acc(1'b0, 8'h02, 8'h00);
    end
    acc(1'b1, 8'hC7, 8'h5A);
    repeat (20) acc(1'($urandom), 8'($urandom_range(3)), 8'($urandom));
    sensors = 1'b1;
    repeat (20) acc(1'($urandom), 8'($urandom_range(3)), 8'($urandom));
    rst_dut();
    #1;
    ctl();
    acc(1'b0, 8'h01, 8'h00);
    acc(1'b0, 8'h02, 8'h00);
    results();
  end
endmodule
`default_nettype wire
